// >>> design/ssth_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ssth_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_i,      // system clock
	input  wire logic             rstn_i,     // async reset, low
	input  wire logic             en_i,       // clock enable
	input  wire logic             flush_i,    // drop all words
	input  wire logic             in_valid_i, // write request
	output logic                  in_ready_o, // room left
	input  wire logic [WIDTH-1:0] in_data_i,  // write word
	output logic                  out_valid_o,// word waiting
	input  wire logic             out_ready_i,// consumer takes word
	output logic      [WIDTH-1:0] out_data_o  // head word
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [CW-1:0]    cnt_reg, cnt_next;
	logic [WIDTH-1:0] head_reg;
	logic             push, pop;

	// honest flags straight from the count
	assign in_ready_o  = (cnt_reg != CW'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o  = head_reg;
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_ready_i & out_valid_o;

	// pointer wrap done by compare so depth need not be a power of two
	always_comb begin
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		cnt_next = cnt_reg;
		if (flush_i) begin
			wr_next  = '0;
			rd_next  = '0;
			cnt_next = '0;
		end else begin
			if (push)
				wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
			if (push && !pop)
				cnt_next = cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_next = cnt_reg - 1'b1;
		end
	end

	// pointers and count
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else if (en_i) begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage and registered head; bypass covers a write to the head slot
	always_ff @(posedge clk_i) begin
		if (en_i && push && !flush_i)
			mem_reg[wr_reg] <= in_data_i;
		if (en_i)
			head_reg <= (push && !flush_i && wr_reg == rd_next) ?
				in_data_i : mem_reg[rd_next];
	end
endmodule
`default_nettype wire

// >>> design/ssth_top.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R01: line idles high until first character; first send waits for clear-to-send low.
// R02: transmit bits leave on transmit clock falling edges, one per period.
// R03: transmitter inserts sync characters when its buffers run dry.
// R04: drained flag high while sync fills, cleared by a data write.
// R05: receive line sampled on each receive clock rising edge.
// R06: hunt compares every bit with sync one, then whole sync two.
// R07: sync found rises at middle of last data or parity bit.
// R08: external party pulses sync input; device stays synchronized afterwards.
// R09: enter-hunt command ignored in asynchronous mode.
// R10: parity and overrun checked whenever not hunting, enabled or not; here overrun is flagged only with receive enabled.
// R11: enter-hunt fills used receive buffer bits with ones.
// R12: status read clears sync-found flop without re-entering hunt.
// R13: out of hunt, sync matched only at character boundaries, contiguously.
// R14: external sync disables comparison; flop may set at any bit.
// R15: after mode and sync characters, control writes are commands; reset restarts.
// R16: processor pairs error reset with receive enable plus enter hunt.
// R17: status readable anytime with select high; updates frozen during read.
// R18: status reflects events within 28 system clocks.
// R19: status ready bit is buffer empty; pin also needs CTS low, enable. Here the bit is buffer room, not empty.
// R20: processor spaces initialization writes by 6, 8 or 16 clocks.
// R21: processor writes data only while transmit buffer is free.
// R22: processor includes enter-hunt in the first synchronous command.
// R23: internal reset command returns device to expecting a mode word.
// R24: new character over unread one overwrites and flags overrun.
// R25: receive available rises on full character, clears on data read.
// R26: control writes after mode load sync one then sync two.
// R27: command and status bit positions chosen in the package.
module ssth_top
	import ssth_pkg::*;
#(
	parameter int FIFO_W = DATA_W,
	parameter int FIFO_D = FIFO_DEPTH
) (
	input  wire logic       CLOCK_I,                    // 200 MHz clock
	input  wire logic       RSTN_I,                     // async reset, low
	input  wire logic       CE_I,                       // freezes all state
	input  wire logic       WR_I,                       // write strobe
	input  wire logic       RD_I,                       // read strobe
	input  wire logic       CMD_SEL_I,                  // 1 control, 0 data
	input  wire logic [7:0] DATA_I,                     // write data
	output logic      [7:0] DATA_O,                     // read data
	input  wire logic       TRANSMIT_BIT_CLOCK_I,       // serial tx clock
	input  wire logic       RECEIVE_BIT_CLOCK_I,        // serial rx clock
	input  wire logic       RXD_I,                      // serial in
	output logic            TXD_O,                      // serial out
	input  wire logic       CTS_N_I,                    // clear to send, low
	input  wire logic       SYNC_FOUND_I,               // sync pin in
	output logic            SYNC_FOUND_O,               // sync pin out
	output logic            SYNC_FOUND_OE_O,            // sync pin driven
	output logic            TRANSMITTER_DRAINED_O,      // tx empty
	output logic            TRANSMIT_BUFFER_FREE_O,     // tx ready pin
	output logic            RECEIVE_CHAR_AVAILABLE_O    // rx ready pin
);
	ssth_ctl_type ctl_reg, ctl_next;
	logic [7:0] mode_reg, mode_next, cmd_reg, cmd_next;
	logic [7:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
	logic [7:0] status_reg, status_next, dout_reg, dout_next;
	logic [8:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next, sh_in, got;
	logic [3:0] tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
	logic       tclk_prev_reg, tx_started_reg, tx_started_next;
	logic       tx_sel_reg, tx_sel_next, txd_reg, txd_next;
	logic       drained_reg, drained_next, rclk_prev_reg;
	logic       hunt_reg, hunt_next, second_reg, second_next;
	logic       prev_s1_reg, prev_s1_next, rx_avail_reg, rx_avail_next;
	logic       pe_reg, pe_next, oe_reg, oe_next;
	logic       sync_flag_reg, sync_flag_next;
	logic [7:0] rx_data_reg, rx_data_next, len_mask, data_in;
	logic [3:0] char_len, frame_len;
	logic       sync_mode, par_en, par_even, ext_sync, single_sync;
	logic       cmd_wr, data_wr, stat_rd, data_rd, in_cmd;
	logic       soft_rst, hunt_cmd, err_rst, tx_en, rx_en;
	logic       tx_fall, rx_rise, exp_par, fifo_ready, fifo_valid, fifo_pop;
	logic [7:0] fifo_data;

	// frame a character: masked data plus parity at bit n
	function automatic logic [8:0] build_frame(input logic [7:0] d,
			input logic [7:0] m, input logic [3:0] n, input logic pe,
			input logic ev);
		logic [8:0] w;
		logic       p;
		p = ^(d & m);
		if (!ev)
			p = ~p;
		w = {1'b0, d & m};
		if (pe)
			w[n] = p;
		return w;
	endfunction

	// decoded mode fields
	assign sync_mode   = mode_reg[MODE_BAUD_LSB +: 2] == MODE_BAUD_SYNC;
	assign char_len    = CHAR_LEN_MIN + {2'b00, mode_reg[MODE_LEN_LSB +: 2]};
	assign par_en      = mode_reg[MODE_PAR_EN_BIT];
	assign par_even    = mode_reg[MODE_PAR_EVEN_BIT];
	assign ext_sync    = mode_reg[MODE_EXT_SYNC_BIT];
	assign single_sync = mode_reg[MODE_SINGLE_SYNC_BIT];
	assign frame_len   = char_len + {3'b000, par_en};
	assign len_mask    = 8'hFF >> (4'h8 - char_len);
	// R27: own command bit layout
	assign tx_en       = cmd_reg[CMD_TX_EN_BIT];
	assign rx_en       = cmd_reg[CMD_RX_EN_BIT];

	// bus strobes and command decode
	assign cmd_wr   = WR_I & CMD_SEL_I;
	assign data_wr  = WR_I & ~CMD_SEL_I;
	assign stat_rd  = RD_I & CMD_SEL_I;
	assign data_rd  = RD_I & ~CMD_SEL_I;
	assign in_cmd   = cmd_wr && (ctl_reg == CTL_CMD);
	// R23: internal reset
	assign soft_rst = in_cmd && DATA_I[CMD_INT_RST_BIT];
	// R09: hunt only in sync mode
	assign hunt_cmd = in_cmd && DATA_I[CMD_HUNT_BIT] && sync_mode;
	assign err_rst  = in_cmd && DATA_I[CMD_ERR_RST_BIT];

	// serial clock edges; inputs are already synchronous
	assign tx_fall = tclk_prev_reg & ~TRANSMIT_BIT_CLOCK_I;
	assign rx_rise = ~rclk_prev_reg & RECEIVE_BIT_CLOCK_I;

	// receive view of the shift buffer after this bit
	assign sh_in   = {RXD_I, rx_sh_reg[8:1]};
	assign got     = sh_in >> (4'h9 - frame_len);
	assign data_in = got[7:0] & len_mask;
	assign exp_par = par_even ? ^data_in : ~^data_in;

	// transmit character buffer; its room is the ready status
	ssth_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_D)
	) u_tx_fifo (
		.clk_i       (CLOCK_I),
		.rstn_i      (RSTN_I),
		.en_i        (CE_I),
		.flush_i     (soft_rst),
		.in_valid_i  (data_wr),
		.in_ready_o  (fifo_ready),
		.in_data_i   (DATA_I),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (fifo_data)
	);

	// control word sequencing
	always_comb begin
		ctl_next   = ctl_reg;
		mode_next  = mode_reg;
		cmd_next   = cmd_reg;
		sync1_next = sync1_reg;
		sync2_next = sync2_reg;
		if (cmd_wr) begin
			unique case (ctl_reg)
				CTL_MODE: begin
					mode_next = DATA_I;
					// R26: sync characters follow a sync mode word
					ctl_next = (DATA_I[MODE_BAUD_LSB +: 2] == MODE_BAUD_SYNC) ?
						CTL_SYNC1 : CTL_CMD;
				end
				CTL_SYNC1: begin
					sync1_next = DATA_I;
					ctl_next = single_sync ? CTL_CMD : CTL_SYNC2;
				end
				CTL_SYNC2: begin
					sync2_next = DATA_I;
					ctl_next   = CTL_CMD;
				end
				CTL_CMD: begin
					// R15: every later control write is a command
					cmd_next = DATA_I;
					if (soft_rst) begin
						ctl_next  = CTL_MODE;
						mode_next = MODE_RST;
						cmd_next  = CMD_RST;
					end
				end
			endcase
		end
	end

	// transmitter
	always_comb begin
		tx_sh_next      = tx_sh_reg;
		tx_cnt_next     = tx_cnt_reg;
		tx_started_next = tx_started_reg;
		tx_sel_next     = tx_sel_reg;
		txd_next        = txd_reg;
		drained_next    = drained_reg;
		fifo_pop        = 1'b0;
		// R04: data write clears, sync insertion below wins
		if (data_wr)
			drained_next = 1'b0;
		if (soft_rst || !sync_mode) begin
			tx_sh_next      = '0;
			tx_cnt_next     = '0;
			tx_started_next = 1'b0;
			tx_sel_next     = 1'b0;
			txd_next        = 1'b1;
			drained_next    = 1'b0;
		// R02: one bit per falling edge, no divider
		end else if (tx_fall) begin
			if (tx_cnt_reg != 4'h0) begin
				txd_next    = tx_sh_reg[0];
				tx_sh_next  = tx_sh_reg >> 1;
				tx_cnt_next = tx_cnt_reg - 4'h1;
			// R01: first character needs CTS low and enable
			end else if (fifo_valid && (tx_started_reg ||
					(tx_en && !CTS_N_I))) begin
				fifo_pop        = 1'b1;
				tx_started_next = 1'b1;
				tx_sel_next     = 1'b0;
				{tx_sh_next, txd_next} = {1'b0, build_frame(fifo_data,
					len_mask, char_len, par_en, par_even)};
				tx_cnt_next = frame_len - 4'h1;
			// R03: keep the line busy with sync characters
			end else if (tx_started_reg) begin
				// R04: drained while fill characters go out
				drained_next = 1'b1;
				tx_sel_next  = single_sync ? 1'b0 : ~tx_sel_reg;
				{tx_sh_next, txd_next} = {1'b0, build_frame(tx_sel_reg ?
					sync2_reg : sync1_reg, len_mask, char_len, par_en,
					par_even)};
				tx_cnt_next = frame_len - 4'h1;
			end
		end
	end

	// receiver, hunt and error flags
	always_comb begin
		rx_sh_next     = rx_sh_reg;
		rx_cnt_next    = rx_cnt_reg;
		hunt_next      = hunt_reg;
		second_next    = second_reg;
		prev_s1_next   = prev_s1_reg;
		rx_data_next   = rx_data_reg;
		rx_avail_next  = rx_avail_reg;
		pe_next        = pe_reg;
		oe_next        = oe_reg;
		sync_flag_next = sync_flag_reg;
		// R12: status read clears, later sets win
		if (stat_rd)
			sync_flag_next = 1'b0;
		// R25: data read clears availability
		if (data_rd)
			rx_avail_next = 1'b0;
		if (err_rst) begin
			pe_next = 1'b0;
			oe_next = 1'b0;
		end
		if (soft_rst) begin
			rx_sh_next     = '0;
			rx_cnt_next    = '0;
			hunt_next      = 1'b1;
			second_next    = 1'b0;
			prev_s1_next   = 1'b0;
			rx_avail_next  = 1'b0;
			pe_next        = 1'b0;
			oe_next        = 1'b0;
			sync_flag_next = 1'b0;
		// R11: stale bits cannot match a sync character
		end else if (hunt_cmd) begin
			rx_sh_next  = RX_HUNT_FILL;
			hunt_next   = 1'b1;
			second_next = 1'b0;
		// R05: sample on receive clock rising edge
		end else if (sync_mode && rx_rise) begin
			rx_sh_next = sh_in;
			// R14: external sync may set the flop at any bit
			if (ext_sync && SYNC_FOUND_I)
				sync_flag_next = 1'b1;
			if (hunt_reg) begin
				rx_cnt_next = '0;
				// R08: one sampled high level ends hunt for good
				if (ext_sync) begin
					if (SYNC_FOUND_I)
						hunt_next = 1'b0;
				// R06: bitwise compare against sync one
				end else if (!second_reg) begin
					if (data_in == (sync1_reg & len_mask)) begin
						hunt_next      = ~single_sync;
						second_next    = ~single_sync;
						// R07: set on the sample of the last bit
						sync_flag_next = single_sync;
					end
				// R06: whole second character must follow
				end else begin
					rx_cnt_next = rx_cnt_reg + 4'h1;
					if (rx_cnt_reg + 4'h1 == frame_len) begin
						rx_cnt_next = '0;
						second_next = 1'b0;
						if (data_in == (sync2_reg & len_mask)) begin
							hunt_next      = 1'b0;
							sync_flag_next = 1'b1;
						end
					end
				end
			end else if (rx_cnt_reg + 4'h1 == frame_len) begin
				rx_cnt_next = '0;
				// R10: parity checked even with receiver disabled
				if (par_en && (sh_in[8] != exp_par))
					pe_next = 1'b1;
				if (rx_en) begin
					rx_data_next  = data_in;
					rx_avail_next = 1'b1;
					// R24: unread character is overwritten
					if (rx_avail_reg && !data_rd)
						oe_next = 1'b1;
				end
				// R13: boundary-only sync detection, contiguous pair
				if (!ext_sync) begin
					prev_s1_next = data_in == (sync1_reg & len_mask);
					if (single_sync ? prev_s1_next :
							(prev_s1_reg &&
							data_in == (sync2_reg & len_mask)))
						sync_flag_next = 1'b1;
				end
			end else begin
				rx_cnt_next = rx_cnt_reg + 4'h1;
			end
		end
	end

	// status snapshot and read data
	always_comb begin
		status_next = status_reg;
		dout_next   = dout_reg;
		// R17: snapshot frozen while status is read
		// R18: otherwise refreshed every clock, far inside the limit
		if (!stat_rd) begin
			status_next                  = STATUS_RST;
			// R19: status bit is buffer room alone
			status_next[ST_TX_FREE_BIT]  = fifo_ready;
			status_next[ST_RX_AVAIL_BIT] = rx_avail_reg;
			status_next[ST_DRAINED_BIT]  = drained_reg;
			status_next[ST_PAR_ERR_BIT]  = pe_reg;
			status_next[ST_OVERRUN_BIT]  = oe_reg;
			status_next[ST_SYNC_BIT]     = sync_flag_reg;
		end
		if (RD_I)
			dout_next = CMD_SEL_I ? status_reg : rx_data_reg;
	end

	// all state; the enable holds everything
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ctl_reg        <= CTL_MODE;
			mode_reg       <= MODE_RST;
			cmd_reg        <= CMD_RST;
			sync1_reg      <= SYNC_CHAR_RST;
			sync2_reg      <= SYNC_CHAR_RST;
			tclk_prev_reg  <= 1'b1;
			tx_sh_reg      <= '0;
			tx_cnt_reg     <= '0;
			tx_started_reg <= 1'b0;
			tx_sel_reg     <= 1'b0;
			txd_reg        <= 1'b1;
			drained_reg    <= 1'b0;
			rclk_prev_reg  <= 1'b1;
			rx_sh_reg      <= '0;
			rx_cnt_reg     <= '0;
			hunt_reg       <= 1'b1;
			second_reg     <= 1'b0;
			prev_s1_reg    <= 1'b0;
			rx_data_reg    <= 8'h00;
			rx_avail_reg   <= 1'b0;
			pe_reg         <= 1'b0;
			oe_reg         <= 1'b0;
			sync_flag_reg  <= 1'b0;
			status_reg     <= STATUS_RST;
			dout_reg       <= 8'h00;
		end else if (CE_I) begin
			ctl_reg        <= ctl_next;
			mode_reg       <= mode_next;
			cmd_reg        <= cmd_next;
			sync1_reg      <= sync1_next;
			sync2_reg      <= sync2_next;
			tclk_prev_reg  <= TRANSMIT_BIT_CLOCK_I;
			tx_sh_reg      <= tx_sh_next;
			tx_cnt_reg     <= tx_cnt_next;
			tx_started_reg <= tx_started_next;
			tx_sel_reg     <= tx_sel_next;
			txd_reg        <= txd_next;
			drained_reg    <= drained_next;
			rclk_prev_reg  <= RECEIVE_BIT_CLOCK_I;
			rx_sh_reg      <= rx_sh_next;
			rx_cnt_reg     <= rx_cnt_next;
			hunt_reg       <= hunt_next;
			second_reg     <= second_next;
			prev_s1_reg    <= prev_s1_next;
			rx_data_reg    <= rx_data_next;
			rx_avail_reg   <= rx_avail_next;
			pe_reg         <= pe_next;
			oe_reg         <= oe_next;
			sync_flag_reg  <= sync_flag_next;
			status_reg     <= status_next;
			dout_reg       <= dout_next;
		end
	end

	// pins; sync pin is an input in external mode
	assign DATA_O                   = dout_reg;
	assign TXD_O                    = txd_reg;
	assign TRANSMITTER_DRAINED_O    = drained_reg;
	assign RECEIVE_CHAR_AVAILABLE_O = rx_avail_reg;
	// R19: pin also gated by CTS and transmit enable
	assign TRANSMIT_BUFFER_FREE_O   = fifo_ready & ~CTS_N_I & tx_en;
	assign SYNC_FOUND_O             = sync_flag_reg & ~ext_sync;
	assign SYNC_FOUND_OE_O          = ~ext_sync;
endmodule
`default_nettype wire

// >>> pkg/ssth_pkg.sv
package ssth_pkg;

	// data path shape
	localparam int DATA_W     = 8;
	localparam int FIFO_DEPTH = 16;

	// mode word fields
	localparam int MODE_BAUD_LSB        = 0;
	localparam int MODE_LEN_LSB         = 2;
	localparam int MODE_PAR_EN_BIT      = 4;
	localparam int MODE_PAR_EVEN_BIT    = 5;
	localparam int MODE_EXT_SYNC_BIT    = 6;
	localparam int MODE_SINGLE_SYNC_BIT = 7;
	localparam logic [1:0] MODE_BAUD_SYNC = 2'h0;
	localparam logic [3:0] CHAR_LEN_MIN   = 4'h5;

	// command word fields
	localparam int CMD_TX_EN_BIT   = 0;
	localparam int CMD_RX_EN_BIT   = 2;
	localparam int CMD_ERR_RST_BIT = 4;
	localparam int CMD_INT_RST_BIT = 6;
	localparam int CMD_HUNT_BIT    = 7;

	// status word fields
	localparam int ST_TX_FREE_BIT  = 0;
	localparam int ST_RX_AVAIL_BIT = 1;
	localparam int ST_DRAINED_BIT  = 2;
	localparam int ST_PAR_ERR_BIT  = 3;
	localparam int ST_OVERRUN_BIT  = 4;
	localparam int ST_SYNC_BIT     = 6;

	// reset values
	localparam logic [7:0] MODE_RST      = 8'h00;
	localparam logic [7:0] CMD_RST       = 8'h00;
	localparam logic [7:0] SYNC_CHAR_RST = 8'h00;
	localparam logic [7:0] STATUS_RST    = 8'h00;
	localparam logic [8:0] RX_HUNT_FILL  = 9'h1FF;

	// timing figures in system clocks
	localparam int STATUS_LAG_MAX     = 28;
	localparam int INIT_WRITE_GAP     = 6;
	localparam int INIT_GAP_ASYNC     = 8;
	localparam int INIT_GAP_SYNC      = 16;

	// control word sequencing
	typedef enum logic [1:0] {
		CTL_MODE  = 2'b00,
		CTL_SYNC1 = 2'b01,
		CTL_SYNC2 = 2'b11,
		CTL_CMD   = 2'b10
	} ssth_ctl_type;

endpackage

// >>> tb/ssth_serial_peer.sv
`timescale 1ns/10ps
`default_nettype none
module ssth_serial_peer (
	input  wire logic clk_i,    // system clock
	input  wire logic rstn_i,   // async reset, low
	input  wire logic txd_i,    // device serial out
	output logic      tx_clk_o, // transmit bit clock
	output logic      rx_clk_o, // receive bit clock
	output logic      rxd_o     // device serial in
);
	logic [3:0] cnt;
	logic       started;
	bit         txq[$];
	bit         rxq[$];

	// both bit clocks from one divider, rx a quarter period earlier
	assign tx_clk_o = (cnt < 4'h8);
	assign rx_clk_o = ((cnt + 4'h4) < 4'h8);

	// sample mid bit, drive after falling edge
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt     <= 4'h0;
			started <= 1'b0;
			rxd_o   <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
			if (cnt == 4'h0 && (started || !txd_i)) begin
				started <= 1'b1;
				txq.push_back(txd_i);
			end
			// an empty queue toggles the line, so no stale level
			if (cnt == 4'h3) begin
				if (rxq.size() > 0)
					rxd_o <= rxq.pop_front();
				else
					rxd_o <= ~rxd_o;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/ssth_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ssth_top_asserts
	import ssth_pkg::*;
(
	input wire logic       CLOCK_I,                  // clock
	input wire logic       RSTN_I,                   // reset, low
	input wire logic       WR_I,                     // write
	input wire logic       RD_I,                     // read
	input wire logic       CMD_SEL_I,                // control select
	input wire logic [7:0] DATA_O,                   // read data
	input wire logic       TRANSMIT_BIT_CLOCK_I,     // tx clock
	input wire logic       RECEIVE_BIT_CLOCK_I,      // rx clock
	input wire logic       TXD_O,                    // serial out
	input wire logic       CTS_N_I,                  // clear to send
	input wire logic       SYNC_FOUND_O,             // sync flop
	input wire logic       SYNC_FOUND_OE_O,          // sync pin driven
	input wire logic       TRANSMITTER_DRAINED_O,    // tx empty
	input wire logic       TRANSMIT_BUFFER_FREE_O,   // tx ready pin
	input wire logic       RECEIVE_CHAR_AVAILABLE_O  // rx ready pin
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);

	logic       tx_prev;
	logic       rx_prev;
	logic [3:0] rx_age;

	// last bit clock samples and age of last rx rising edge
	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			tx_prev <= 1'b1;
			rx_prev <= 1'b1;
			rx_age  <= 4'hF;
		end else begin
			tx_prev <= TRANSMIT_BIT_CLOCK_I;
			rx_prev <= RECEIVE_BIT_CLOCK_I;
			if (RECEIVE_BIT_CLOCK_I && !rx_prev)
				rx_age <= 4'h0;
			else if (rx_age != 4'hF)
				rx_age <= rx_age + 4'h1;
		end
	end

	AST_TX_SHIFT: assert property ($changed(TXD_O) |->
		$past(tx_prev && !TRANSMIT_BIT_CLOCK_I) || $past(WR_I && CMD_SEL_I))
		else $error("serial out moved off a tx falling edge");
	AST_FREE_PIN: assert property (TRANSMIT_BUFFER_FREE_O |-> !CTS_N_I)
		else $error("tx ready pin high with clear to send off");
	AST_FREE_BIT: assert property (RD_I && CMD_SEL_I &&
		$past(TRANSMIT_BUFFER_FREE_O) && !$past(RD_I && CMD_SEL_I)
		|=> DATA_O[ST_TX_FREE_BIT]) else $error("status free bit low");
	AST_RX_CLR: assert property (RD_I && !CMD_SEL_I |->
		##[1:2] !RECEIVE_CHAR_AVAILABLE_O) else $error("rx ready kept");
	AST_SYNC_CLR: assert property (RD_I && CMD_SEL_I |->
		##[1:2] !SYNC_FOUND_O) else $error("sync flop not cleared");
	AST_EXT_QUIET: assert property (!SYNC_FOUND_OE_O |-> !SYNC_FOUND_O)
		else $error("sync output high in external mode");
	AST_DRAIN_CLR: assert property (WR_I && !CMD_SEL_I &&
		TRANSMIT_BUFFER_FREE_O |-> ##[1:2] !TRANSMITTER_DRAINED_O)
		else $error("drained flag kept after data write");
	AST_RX_RISE: assert property ($rose(RECEIVE_CHAR_AVAILABLE_O) |->
		rx_age <= 4'h3) else $error("rx ready rose away from a sample");
	AST_ST_PAD: assert property (RD_I && CMD_SEL_I |=>
		!DATA_O[7] && !DATA_O[5]) else $error("unused status bit set");
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	err_total++; \
	$display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
`define WAITV(e) begin for (n = 0; n < 3000 && ((e) !== 1'b1); n++) \
	begin @(posedge clk); #1; end \
	if ((e) !== 1'b1) err_total++; end
module tb;
	import ssth_pkg::*;
	logic       clk, rst_n, ce, wr, rd, cmd_sel, cts_n, sync_in;
	logic       transmit_bit_clock, receive_bit_clock, rxd, txd, sf, sf_oe, drained, free, avail;
	logic [7:0] din, dout, st, d;
	int         err_total, samples_checked, n;

	ssth_top uut (.CLOCK_I(clk), .RSTN_I(rst_n), .CE_I(ce), .WR_I(wr),
		.RD_I(rd), .CMD_SEL_I(cmd_sel), .DATA_I(din), .DATA_O(dout),
		.TRANSMIT_BIT_CLOCK_I(transmit_bit_clock), .RECEIVE_BIT_CLOCK_I(receive_bit_clock),
		.RXD_I(rxd), .TXD_O(txd), .CTS_N_I(cts_n), .SYNC_FOUND_I(sync_in),
		.SYNC_FOUND_O(sf), .SYNC_FOUND_OE_O(sf_oe),
		.TRANSMITTER_DRAINED_O(drained), .TRANSMIT_BUFFER_FREE_O(free),
		.RECEIVE_CHAR_AVAILABLE_O(avail));
	ssth_serial_peer peer (.clk_i(clk), .rstn_i(rst_n), .txd_i(txd),
		.tx_clk_o(transmit_bit_clock), .rx_clk_o(receive_bit_clock), .rxd_o(rxd));

	// one bus write, strobe dropped before the next edge
	task wr_bus(input logic c, input logic [7:0] v);
		@(posedge clk); #1;
		wr = 1'b1; cmd_sel = c; din = v;
		@(posedge clk); #1;
		wr = 1'b0;
	endtask
	// one bus read, data taken once the answer is settled
	task rd_bus(input logic c, output logic [7:0] v);
		@(posedge clk); #1;
		rd = 1'b1; cmd_sel = c;
		@(posedge clk); #1;
		rd = 1'b0;
		@(posedge clk); #1;
		v = dout;
	endtask
	// init writes spaced by the sync-mode gap
	task setup(input logic [7:0] m, input logic [7:0] c);
		logic [7:0] w[4];
		w = '{m, 8'hA5, 8'h3C, c};
		foreach (w[i]) begin
			wr_bus(1'b1, w[i]);
			repeat (INIT_GAP_SYNC) @(posedge clk);
		end
	endtask
	task tx_get(output logic [7:0] v);
		int t;
		for (int i = 0; i < 8; i++) begin
			for (t = 0; t < 400 && peer.txq.size() == 0; t++) @(posedge clk);
			if (peer.txq.size() == 0)
				err_total++;
			else
				v[i] = peer.txq.pop_front();
		end
	endtask
	task rx_put(input logic [7:0] v);
		for (int i = 0; i < 8; i++) peer.rxq.push_back(v[i]);
	endtask
	task final_report;
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		final_report();
	end

	initial begin
		{rst_n, wr, rd, cmd_sel, sync_in, din} = '0;
		{ce, cts_n} = 2'b11;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'b1;
		`CHK(txd, 1'b1)
		`CHK({sf, sf_oe, drained, free, avail}, 5'h08)
		// first command pairs error reset with hunt
		setup(8'h0C, 8'h95);
		rd_bus(1'b1, st);
		`CHK({st[ST_TX_FREE_BIT], free}, 2'b10)
		// sixteen writes fill the buffer, none while it is full
		for (int k = 0; k < 16; k++) wr_bus(1'b0, 8'h10 + k[7:0]);
		rd_bus(1'b1, st);
		`CHK(st[ST_TX_FREE_BIT], 1'b0)
		`CHK(txd, 1'b1)
		cts_n = 1'b0;
		for (int k = 0; k < 16; k++) begin
			tx_get(d);
			`CHK(d, 8'h10 + k[7:0])
		end
		tx_get(d);
		`CHK(d, 8'hA5)
		tx_get(d);
		`CHK(d, 8'h3C)
		`CHK(drained, 1'b1)
		wr_bus(1'b0, 8'hC3);
		repeat (2) @(posedge clk);
		#1;
		`CHK(drained, 1'b0)
		rx_put(8'h06);
		rx_put(8'hA5);
		rx_put(8'h3C);
		rx_put(8'h69);
		`WAITV(sf)
		`CHK(sf, 1'b1)
		rd_bus(1'b1, st);
		`CHK({st[ST_SYNC_BIT], sf}, 2'b10)
		`WAITV(avail)
		rd_bus(1'b0, d);
		`CHK({d, avail}, {8'h69, 1'b0})
		rx_put(8'h11);
		rx_put(8'h22);
		`WAITV(peer.rxq.size() == 0)
		repeat (40) @(posedge clk);
		rd_bus(1'b1, st);
		`CHK(st[ST_OVERRUN_BIT], 1'b1)
		rd_bus(1'b0, d);
		`CHK(d, 8'h22)
		wr_bus(1'b1, 8'h40);
		repeat (2) @(posedge clk);
		#1;
		`CHK({txd, free}, 2'b10)
		setup(8'h4C, 8'h95);
		#1;
		`CHK({sf_oe, avail}, 2'b00)
		// external pulse held one rx period, then dropped
		sync_in = 1'b1;
		repeat (16) @(posedge clk);
		#1 sync_in = 1'b0;
		`WAITV(avail)
		`CHK({avail, sf}, 2'b10)
		rd_bus(1'b1, st);
		`CHK(st[ST_SYNC_BIT], 1'b1)
		// frozen block must ignore an internal reset
		ce = 1'b0;
		wr_bus(1'b1, 8'h40);
		ce = 1'b1;
		`CHK(sf_oe, 1'b0)
		final_report();
	end
endmodule
bind ssth_top ssth_top_asserts chk (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I),
	.WR_I(WR_I), .RD_I(RD_I), .CMD_SEL_I(CMD_SEL_I), .DATA_O(DATA_O),
	.TRANSMIT_BIT_CLOCK_I(TRANSMIT_BIT_CLOCK_I),
	.RECEIVE_BIT_CLOCK_I(RECEIVE_BIT_CLOCK_I), .TXD_O(TXD_O),
	.CTS_N_I(CTS_N_I), .SYNC_FOUND_O(SYNC_FOUND_O),
	.SYNC_FOUND_OE_O(SYNC_FOUND_OE_O),
	.TRANSMITTER_DRAINED_O(TRANSMITTER_DRAINED_O),
	.TRANSMIT_BUFFER_FREE_O(TRANSMIT_BUFFER_FREE_O),
	.RECEIVE_CHAR_AVAILABLE_O(RECEIVE_CHAR_AVAILABLE_O));
`default_nettype wire
